/* rtl/eps_pkg.sv */
package eps_pkg;

    // ----------------------------------------------------------------
    // clock and time base
    // ----------------------------------------------------------------
    localparam int CLK_MHZ        = 200;
    localparam int TICK_NS        = 500;
    localparam int TICK_CYCLES    = (TICK_NS * CLK_MHZ + 999) / 1000;
    localparam int TICKS_PER_US   = 1000 / TICK_NS;

    // ----------------------------------------------------------------
    // programming times
    // ----------------------------------------------------------------
    localparam int T_ADDR_SETUP_NS = 10000;
    localparam int T_ARM_SETUP_NS  = 10000;
    localparam int T_DATA_SETUP_NS = 10000;
    localparam int T_ADDR_HOLD_NS  = 1000;
    localparam int T_DATA_HOLD_NS  = 1000;
    localparam int T_ARM_HOLD_NS   = 500;
    localparam int T_READ_DELAY_NS = 10000;

    localparam int SETUP_NS = (T_ADDR_SETUP_NS > T_DATA_SETUP_NS) ?
                              T_ADDR_SETUP_NS : T_DATA_SETUP_NS;
    localparam int SETUP_ALL_NS = (SETUP_NS > T_ARM_SETUP_NS) ? SETUP_NS : T_ARM_SETUP_NS;
    localparam int HOLD_NS = (T_ADDR_HOLD_NS > T_DATA_HOLD_NS) ?
                             T_ADDR_HOLD_NS : T_DATA_HOLD_NS;
    localparam int HOLD_ALL_NS = (HOLD_NS > T_ARM_HOLD_NS) ? HOLD_NS : T_ARM_HOLD_NS;

    localparam int SETUP_TICKS = (SETUP_ALL_NS + TICK_NS - 1) / TICK_NS;
    localparam int HOLD_TICKS  = (HOLD_ALL_NS + TICK_NS - 1) / TICK_NS;
    localparam int READ_TICKS  = (T_READ_DELAY_NS + TICK_NS - 1) / TICK_NS;

    // ----------------------------------------------------------------
    // pulse and loop limits
    // ----------------------------------------------------------------
    localparam int PULSE_MIN_US = 100;
    localparam int PULSE_MAX_US = 1000;
    localparam int TOTAL_MIN_US = 100000;
    localparam int LOOPS_MIN    = 100;
    localparam int LOOPS_MAX    = 1000;
    localparam int CFG_W        = 10;

    // ----------------------------------------------------------------
    // array shape and buffering
    // ----------------------------------------------------------------
    localparam int ADDR_W     = 11;
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int TIMER_W    = 12;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [5:0] {
        EPS_IDLE  = 6'h01,
        EPS_FETCH = 6'h02,
        EPS_SETUP = 6'h04,
        EPS_PULSE = 6'h08,
        EPS_HOLD  = 6'h10,
        EPS_READ  = 6'h20
    } eps_state_type;

endpackage

/* rtl/eps_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module eps_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = eps_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("fifo width must be positive");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW:0]      next_count;
    logic             push;
    logic             load;

    // ----------------------------------------------------------------
    // flow control
    // ----------------------------------------------------------------
    always_comb begin
        push       = in_valid && in_ready;
        load       = (count != '0) && (!out_valid || out_ready);
        next_count = count;
        if (push && !load) begin
            next_count = count + 1'b1;
        end else if (!push && load) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (load) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count    <= next_count;
            in_ready <= next_count < (PW+1)'(DEPTH);
        end
    end

    // ----------------------------------------------------------------
    // registered read stage
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* rtl/eps_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module eps_sequencer #(
    parameter int ADDR_W      = eps_pkg::ADDR_W,
    parameter int DATA_W      = eps_pkg::DATA_W,
    parameter int FIFO_DEPTH  = eps_pkg::FIFO_DEPTH,
    parameter int TICK_CYCLES = eps_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // run control
    input  wire logic                     start,
    input  wire logic [eps_pkg::CFG_W-1:0] cfg_pulse_us,
    input  wire logic [eps_pkg::CFG_W-1:0] cfg_loops,
    // word stream, one word per address per loop
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [DATA_W-1:0]        in_data,
    input  wire logic                     in_blank,
    // status
    output logic                          busy,
    output logic                          done,
    output logic                          cfg_error,
    output logic [eps_pkg::CFG_W-1:0]     loop_index,
    output logic [DATA_W-1:0]             verify_data,
    // device pins
    output logic [ADDR_W-1:0]             addr,
    output logic [DATA_W-1:0]             byte_lines_out,
    output logic                          byte_lines_oe,
    input  wire logic [DATA_W-1:0]        byte_lines_in,
    output logic                          arm_high_level,
    output logic                          pulse_high_level
);

    localparam int CW = eps_pkg::CFG_W;
    localparam int TW = eps_pkg::TIMER_W;
    localparam int DW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_shape
        $error("address and data widths must be positive");
    end
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("tick divider must be at least one cycle");
    end
    if (eps_pkg::PULSE_MAX_US * eps_pkg::TICKS_PER_US >= 2 ** TW) begin : g_bad_timer
        $error("timer too narrow for the longest pulse");
    end

    // ----------------------------------------------------------------
    // configuration check
    // ----------------------------------------------------------------
    function automatic logic cfg_valid(input logic [CW-1:0] width_us,
                                       input logic [CW-1:0] loops);
        logic [2*CW-1:0] total;
        total = width_us * loops;
        cfg_valid = (width_us >= CW'(eps_pkg::PULSE_MIN_US)) &&
                    (width_us <= CW'(eps_pkg::PULSE_MAX_US)) &&
                    (loops >= CW'(eps_pkg::LOOPS_MIN)) &&
                    (loops <= CW'(eps_pkg::LOOPS_MAX)) &&
                    (total >= (2*CW)'(eps_pkg::TOTAL_MIN_US));
    endfunction

    eps_pkg::eps_state_type state;
    eps_pkg::eps_state_type next_state;

    logic [CW-1:0]     pulse_us;
    logic [CW-1:0]     loops;
    logic [TW-1:0]     timer;
    logic [TW-1:0]     next_timer;
    logic              timer_load;
    logic [DW-1:0]     div;
    logic              tick;
    logic              timer_zero;
    logic              go;
    logic              last_addr;
    logic              last_loop;
    logic              fifo_valid;
    logic              fifo_ready;
    logic [DATA_W:0]   fifo_data;

    // ----------------------------------------------------------------
    // word buffer
    // ----------------------------------------------------------------
    eps_fifo #(
        .WIDTH (DATA_W + 1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   ({in_blank, in_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    // ----------------------------------------------------------------
    // half-microsecond tick and wait timer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst || timer_load) begin
            div  <= '0;
            tick <= 1'b0;
        end else if (div == DW'(TICK_CYCLES - 1)) begin
            div  <= '0;
            tick <= 1'b1;
        end else begin
            div  <= div + 1'b1;
            tick <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer <= '0;
        end else if (timer_load) begin
            timer <= next_timer;
        end else if (tick && timer != '0) begin
            timer <= timer - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // sequence control
    // ----------------------------------------------------------------
    always_comb begin
        timer_zero = (timer == '0);
        go         = start && cfg_valid(cfg_pulse_us, cfg_loops);
        last_addr  = (addr == {ADDR_W{1'b1}});
        last_loop  = (loop_index == loops - 1'b1);
        fifo_ready = (state == eps_pkg::EPS_FETCH);
        next_state = state;
        timer_load = 1'b0;
        next_timer = '0;
        unique case (state)
            eps_pkg::EPS_IDLE: begin
                if (go) begin
                    next_state = eps_pkg::EPS_FETCH;
                end
            end
            eps_pkg::EPS_FETCH: begin
                if (fifo_valid) begin
                    next_state = eps_pkg::EPS_SETUP;
                    timer_load = 1'b1;
                    next_timer = TW'(eps_pkg::SETUP_TICKS);
                end
            end
            eps_pkg::EPS_SETUP: begin
                if (timer_zero) begin
                    next_state = eps_pkg::EPS_PULSE;
                    timer_load = 1'b1;
                    next_timer = TW'(pulse_us * eps_pkg::TICKS_PER_US);
                end
            end
            eps_pkg::EPS_PULSE: begin
                if (timer_zero) begin
                    next_state = eps_pkg::EPS_HOLD;
                    timer_load = 1'b1;
                    next_timer = TW'(eps_pkg::HOLD_TICKS);
                end
            end
            eps_pkg::EPS_HOLD: begin
                if (timer_zero) begin
                    if (last_addr && last_loop) begin
                        next_state = eps_pkg::EPS_READ;
                        timer_load = 1'b1;
                        next_timer = TW'(eps_pkg::READ_TICKS);
                    end else begin
                        next_state = eps_pkg::EPS_FETCH;
                    end
                end
            end
            eps_pkg::EPS_READ: begin
                if (timer_zero) begin
                    next_state = eps_pkg::EPS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= eps_pkg::EPS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // configuration capture and status
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulse_us  <= '0;
            loops     <= '0;
            cfg_error <= 1'b0;
        end else if (state == eps_pkg::EPS_IDLE && start) begin
            cfg_error <= !go;
            if (go) begin
                pulse_us <= cfg_pulse_us;
                loops    <= cfg_loops;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy        <= 1'b0;
            done        <= 1'b0;
            verify_data <= '0;
        end else begin
            if (state == eps_pkg::EPS_IDLE && go) begin
                busy <= 1'b1;
                done <= 1'b0;
            end
            if (state == eps_pkg::EPS_READ && timer_zero) begin
                busy        <= 1'b0;
                done        <= 1'b1;
                verify_data <= byte_lines_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // address and loop counting
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr       <= '0;
            loop_index <= '0;
        end else if (state == eps_pkg::EPS_IDLE && go) begin
            addr       <= '0;
            loop_index <= '0;
        end else if (state == eps_pkg::EPS_HOLD && timer_zero && !(last_addr && last_loop)) begin
            addr <= addr + 1'b1;
            if (last_addr) begin
                loop_index <= loop_index + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // data lines
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            byte_lines_out <= '0;
            byte_lines_oe  <= 1'b0;
        end else begin
            if (state == eps_pkg::EPS_IDLE && go) begin
                byte_lines_oe <= 1'b1;
            end
            if (state == eps_pkg::EPS_HOLD && timer_zero && last_addr && last_loop) begin
                byte_lines_oe <= 1'b0;
            end
            if (state == eps_pkg::EPS_FETCH && fifo_valid) begin
                if (fifo_data[DATA_W]) begin
                    byte_lines_out <= {DATA_W{1'b1}};
                end else begin
                    byte_lines_out <= fifo_data[DATA_W-1:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // enable and pulse pins
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            arm_high_level <= 1'b0;
        end else if (state == eps_pkg::EPS_IDLE && go) begin
            arm_high_level <= 1'b1;
        end else if (state == eps_pkg::EPS_HOLD && timer_zero && last_addr && last_loop) begin
            arm_high_level <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulse_high_level <= 1'b0;
        end else if (state == eps_pkg::EPS_SETUP && timer_zero) begin
            pulse_high_level <= 1'b1;
        end else if (state == eps_pkg::EPS_PULSE && timer_zero) begin
            pulse_high_level <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* verification/eps_sequencer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module eps_sequencer_chk #(
    parameter int ADDR_W      = eps_pkg::ADDR_W,
    parameter int DATA_W      = eps_pkg::DATA_W,
    parameter int FIFO_DEPTH  = eps_pkg::FIFO_DEPTH,
    parameter int TICK_CYCLES = eps_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic                      core_clk,
    input wire logic                      rst,
    // run control and status
    input wire logic                      start,
    input wire logic [eps_pkg::CFG_W-1:0] cfg_pulse_us,
    input wire logic [eps_pkg::CFG_W-1:0] cfg_loops,
    input wire logic                      busy,
    input wire logic                      done,
    input wire logic                      cfg_error,
    input wire logic [eps_pkg::CFG_W-1:0] loop_index,
    // device pins
    input wire logic [ADDR_W-1:0]         addr,
    input wire logic [DATA_W-1:0]         byte_lines_out,
    input wire logic                      byte_lines_oe,
    input wire logic                      arm_high_level,
    input wire logic                      pulse_high_level
);
    localparam int SU = eps_pkg::SETUP_TICKS * TICK_CYCLES;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    logic                      cfg_ok;
    logic [eps_pkg::CFG_W-1:0] pul;
    int                        pw;
    int                        wcnt;
    int                        scnt;
    int                        pcnt;

    assign cfg_ok = cfg_pulse_us >= 100 && cfg_pulse_us <= 1000 && cfg_loops >= 100
                    && cfg_loops <= 1000 && cfg_pulse_us * cfg_loops >= 100000;
    assign pw = int'(pul) * 2 * TICK_CYCLES;

    // ----
    // helper counters
    // ----
    always_ff @(posedge core_clk)
        pul <= rst ? '0 : (start && !busy && cfg_ok) ? cfg_pulse_us : pul;
    always_ff @(posedge core_clk) wcnt <= (rst || !pulse_high_level) ? 0 : wcnt + 1;
    always_ff @(posedge core_clk)
        scnt <= (rst || $changed(addr) || $changed(byte_lines_out)) ? 0 : scnt + 1;
    always_ff @(posedge core_clk)
        pcnt <= (rst || $changed(addr)) ? 0 : pcnt + int'($rose(pulse_high_level));

    sequence s_arm_drop;
        $fell(arm_high_level) && !pulse_high_level && !byte_lines_oe;
    endsequence
    sequence s_quiet;
        (busy && !pulse_high_level && $stable(addr)) [*8];
    endsequence

    a_start_arms: assert property (
        start && !busy && cfg_ok |=> busy && arm_high_level && byte_lines_oe
        && addr == '0 && !done && !cfg_error) else $error("start did not arm");
    a_bad_cfg: assert property (
        start && !busy && !cfg_ok |=> cfg_error && !busy && !arm_high_level)
        else $error("bad config accepted");
    a_pulse_armed: assert property (
        pulse_high_level |-> arm_high_level && byte_lines_oe && busy)
        else $error("pulse outside programming");
    a_addr_steady: assert property (
        pulse_high_level |=> $stable(addr) && $stable(byte_lines_out))
        else $error("address or data moved during pulse");
    a_one_pulse: assert property (pcnt <= 1)
        else $error("two pulses on one address");
    a_setup_time: assert property (
        $rose(pulse_high_level) |-> scnt >= SU - 1) else $error("setup too short");
    a_pulse_width: assert property (
        $fell(pulse_high_level) |-> wcnt >= pw && wcnt <= pw + 2)
        else $error("pulse width wrong");
    a_arm_exit: assert property (s_arm_drop |-> s_quiet)
        else $error("address moved after enable fell");
    a_loop_wrap: assert property (
        busy && $past(busy) && $changed(loop_index) |-> addr == '0
        && $past(addr) == '1 && loop_index == $past(loop_index) + 1)
        else $error("loop count moved off a wrap");
    a_run_end: assert property (
        $fell(busy) |-> done && !arm_high_level && !byte_lines_oe)
        else $error("run ended in wrong state");
endmodule

bind eps_sequencer eps_sequencer_chk #(
    .ADDR_W(ADDR_W), .DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH), .TICK_CYCLES(TICK_CYCLES)
) u_chk (
    .core_clk(core_clk), .rst(rst), .start(start), .cfg_pulse_us(cfg_pulse_us),
    .cfg_loops(cfg_loops), .busy(busy), .done(done), .cfg_error(cfg_error),
    .loop_index(loop_index), .addr(addr), .byte_lines_out(byte_lines_out),
    .byte_lines_oe(byte_lines_oe), .arm_high_level(arm_high_level),
    .pulse_high_level(pulse_high_level)
);
`default_nettype wire

/* verification/eps_rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eps_rom_model #(
    parameter int ADDR_W = 1,
    parameter int RD_DLY = 17
) (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // pins from the programmer
    input  wire logic [ADDR_W-1:0]           addr,
    input  wire logic [7:0]                  byte_lines_out,
    input  wire logic                        byte_lines_oe,
    input  wire logic                        arm_high_level,
    input  wire logic                        pulse_high_level,
    // data lines and status
    output logic      [7:0]                  byte_lines_in,
    output logic      [(1<<ADDR_W)-1:0][7:0] cells,
    output var int                           pulse_total,
    output var int                           fault_count
);
    logic [ADDR_W-1:0] prev_a;
    logic [ADDR_W-1:0] last_pa;
    logic              prev_p;
    logic              prev_arm;
    logic              had;
    logic [7:0]        last_d;
    int                rd_cnt;

    // undriven lines toggle so stale data never passes
    assign byte_lines_in = byte_lines_oe ? byte_lines_out :
        (!arm_high_level && rd_cnt >= RD_DLY) ? cells[addr] : ~last_d;

    always @(posedge core_clk) begin
        if (rst) begin
            cells <= '1;
            pulse_total <= 0;
            fault_count <= 0;
            had <= 1'b0;
            rd_cnt <= 0;
        end else begin
            if (pulse_high_level && !prev_p) begin
                cells[addr] <= cells[addr] & byte_lines_out;
                pulse_total <= pulse_total + 1;
                had <= 1'b1;
                last_pa <= addr;
            end
            fault_count <= fault_count
                + int'(pulse_high_level && !(arm_high_level && byte_lines_oe))
                + int'(pulse_high_level && !prev_p && had && addr == last_pa)
                + int'((prev_p || pulse_high_level)
                       && (addr != prev_a || arm_high_level != prev_arm))
                + int'(prev_arm && !arm_high_level && addr != prev_a);
            rd_cnt <= arm_high_level ? 0 : rd_cnt + 1;
        end
        prev_p <= pulse_high_level;
        prev_arm <= arm_high_level;
        prev_a <= addr;
        last_d <= byte_lines_in;
    end
endmodule
`default_nettype wire

/* verification/eps_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module eps_sequencer_tb;
    localparam int AW = 1;
    localparam int NW = 200;
    logic                      core_clk = 1'b0;
    logic                      rst = 1'b1;
    logic                      start = 1'b0;
    logic [eps_pkg::CFG_W-1:0] cfg_pulse_us = '0;
    logic [eps_pkg::CFG_W-1:0] cfg_loops = '0;
    logic                      in_valid = 1'b0;
    logic [7:0]                in_data = 8'h00;
    logic                      in_blank = 1'b0;
    logic                      feed = 1'b0;
    logic                      in_ready, busy, done, cfg_error, byte_lines_oe;
    logic                      arm_high_level, pulse_high_level;
    logic [eps_pkg::CFG_W-1:0] loop_index;
    logic [7:0]                verify_data, byte_lines_out, byte_lines_in;
    logic [AW-1:0]             addr;
    logic [(1<<AW)-1:0][7:0]   cells;
    int                        err_total = 0, num_checks = 0, sent = 0, cyc = 0;
    int                        pulse_total, fault_count;

    always #2.5 core_clk = ~core_clk;

    eps_sequencer #(.ADDR_W(AW), .TICK_CYCLES(1)) dut (
        .core_clk(core_clk), .rst(rst), .start(start), .cfg_pulse_us(cfg_pulse_us),
        .cfg_loops(cfg_loops), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .in_blank(in_blank), .busy(busy), .done(done), .cfg_error(cfg_error),
        .loop_index(loop_index), .verify_data(verify_data), .addr(addr),
        .byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe),
        .byte_lines_in(byte_lines_in), .arm_high_level(arm_high_level),
        .pulse_high_level(pulse_high_level)
    );

    eps_rom_model #(.ADDR_W(AW), .RD_DLY(17)) u_rom (
        .core_clk(core_clk), .rst(rst), .addr(addr), .byte_lines_out(byte_lines_out),
        .byte_lines_oe(byte_lines_oe), .arm_high_level(arm_high_level),
        .pulse_high_level(pulse_high_level), .byte_lines_in(byte_lines_in),
        .cells(cells), .pulse_total(pulse_total), .fault_count(fault_count)
    );

    // ----
    // word source: address 0 blank, address 1 data, every loop
    // ----
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (in_valid && in_ready) sent = sent + 1;
        if (!in_valid || in_ready) begin
            in_valid <= feed && sent < NW && cyc % 7 != 3;
            in_data <= sent[0] ? 8'h3C : 8'h00;
            in_blank <= !sent[0];
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic go(input int p, input int l);
        @(posedge core_clk);
        cfg_pulse_us <= 10'(p);
        cfg_loops <= 10'(l);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        #1;
    endtask

    task automatic t_bad_cfg;
        int p[5] = '{99, 1001, 1000, 100, 100};
        int l[5] = '{1000, 100, 99, 1001, 100};
        for (int i = 0; i < 5; i++) begin
            go(p[i], l[i]);
            chk({cfg_error, busy, arm_high_level}, 3'b100);
        end
    endtask

    task automatic t_fill;
        feed <= 1'b1;
        for (int i = 0; i < 60 && in_ready !== 1'b0; i++) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        #1;
        chk({in_ready, 8'(sent)}, {1'b0, 8'(eps_pkg::FIFO_DEPTH + 1)});
    endtask

    task automatic t_run;
        go(1000, 100);
        chk({busy, arm_high_level, byte_lines_oe, done, cfg_error}, 5'b11100);
        chk(32'(addr), 0);
        repeat (50) @(posedge core_clk);
        go(1, 1);
        chk({busy, cfg_error}, 2'b10);
        for (int i = 0; i < 500000 && done !== 1'b1; i++) @(posedge core_clk);
        #1;
        chk({busy, arm_high_level, byte_lines_oe, pulse_high_level}, 4'b0000);
        chk(32'(addr), (1 << AW) - 1);
        chk(32'(loop_index), 99);
        chk(verify_data, 8'h3C);
        chk(cells, 16'h3CFF);
        chk(pulse_total, NW);
        chk(fault_count, 0);
        chk({in_ready, 8'(sent)}, {1'b1, 8'(NW)});
        go(99, 99);
        chk({done, cfg_error, busy}, 3'b110);
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk({busy, done, cfg_error}, 3'b000);
        chk({arm_high_level, pulse_high_level, byte_lines_oe, in_ready}, 4'b0001);
        t_bad_cfg;
        t_fill;
        t_run;
        final_report;
    end

    initial begin
        repeat (600000) @(posedge core_clk);
        err_total++;
        final_report;
    end
endmodule
`default_nettype wire
